/* hws_pkg.sv */
`default_nettype none
package hws_pkg;
   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int unsigned CLK_KHZ      = 125000;
   localparam int unsigned TICK_SLOW_MS = 5;
   localparam int unsigned TICK_FAST_MS = 1;
   localparam int unsigned PAUSE_MS     = 10;
   localparam int unsigned BRAKE_MS     = 50;
   localparam int unsigned TICK_SLOW_CYC = TICK_SLOW_MS * CLK_KHZ;
   localparam int unsigned TICK_FAST_CYC = TICK_FAST_MS * CLK_KHZ;
   localparam int unsigned PAUSE_CYC     = PAUSE_MS * CLK_KHZ;
   localparam int unsigned BRAKE_CYC     = BRAKE_MS * CLK_KHZ;

   // ==========================================================
   // Memory and library layout
   // ==========================================================
   localparam int unsigned MEM_BYTES   = 1024;
   localparam int unsigned MEM_AW      = 10;
   localparam int unsigned HDR_BYTES   = 3;
   localparam logic [6:0]  MAX_EFFECTS = 7'h7f;
   localparam logic [4:0]  SIZE_MAX    = 5'h1e;
   localparam int unsigned CFG_SIZE_LSB = 0;
   localparam int unsigned CFG_REP_LSB  = 5;
   localparam logic [2:0]  REP_FOREVER  = 3'h7;

   // ==========================================================
   // Register offsets, fields and reset values
   // ==========================================================
   localparam logic [7:0] REG_STATUS  = 8'h01;
   localparam logic [7:0] REG_CTRL1   = 8'h07;
   localparam logic [7:0] REG_CTRL2   = 8'h08;
   localparam logic [7:0] REG_LAUNCH  = 8'h0c;
   localparam logic [7:0] REG_PLAY    = 8'h0d;
   localparam logic [7:0] REG_RTP     = 8'h0e;
   localparam logic [7:0] REG_SLOT1   = 8'h0f;
   localparam logic [7:0] REG_LOOP_LO = 8'h17;
   localparam logic [7:0] REG_LOOP_HI = 8'h18;
   localparam logic [7:0] REG_MAIN    = 8'h19;
   localparam int unsigned STAT_ERR_BIT = 4;
   localparam int unsigned MODE_LSB     = 0;
   localparam int unsigned TFUNC_LSB    = 2;
   localparam int unsigned BRAKE_BIT    = 3;
   localparam int unsigned INTV_BIT     = 5;
   localparam logic [7:0] RST_CTRL1 = 8'h44;
   localparam logic [7:0] RST_CTRL2 = 8'h88;
   localparam logic [7:0] RST_RTP   = 8'h7f;
   localparam logic [7:0] RST_SLOT1 = 8'h01;

   // Modes and trigger pin functions
   localparam logic [1:0] MODE_RTP   = 2'h0;
   localparam logic [1:0] MODE_SEQ   = 2'h1;
   localparam logic [1:0] TPIN_PULSE = 2'h0;
   localparam logic [1:0] TPIN_LEVEL = 2'h1;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_RTP   = 8'h02,
      ST_SLOT  = 8'h04,
      ST_HDR   = 8'h08,
      ST_DATA  = 8'h10,
      ST_HOLD  = 8'h20,
      ST_PAUSE = 8'h40,
      ST_BRAKE = 8'h80
   } hws_state_type;
endpackage : hws_pkg
`default_nettype wire

/* hws_mem_if.sv */
`default_nettype none
interface hws_mem_if;
   logic       wr_en;
   logic [9:0] wr_addr;
   logic [7:0] wr_data;
   logic [9:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data);
endinterface : hws_mem_if
`default_nettype wire

/* hws_wave_mem.sv */
`default_nettype none
module hws_wave_mem
   import hws_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Memory port
   hws_mem_if.mem   mp
);
   // ==========================================================
   // Library storage
   // ==========================================================
   logic [7:0] mem_q [MEM_BYTES];

   // Host fills the library; no reset so it maps onto plain RAM
   always_ff @(posedge core_clk) begin
      if (mp.wr_en) begin
         mem_q[mp.wr_addr] <= mp.wr_data;
      end
   end

   // Read is immediate from the registered engine address
   assign mp.rd_data = mem_q[mp.rd_addr];
endmodule : hws_wave_mem
`default_nettype wire

/* hws_sequencer.sv */
// Notes on behaviour
// - One kilobyte library memory inside device
// - Three-byte header block per effect, max 127
// - Block: two-byte start address, config byte
// - Effect ID equals header block position
// - Size even, 2 to 30, else error
// - Repeat field: n+1 plays, 7 forever
// - Voltage byte (ramp flag) then time byte
// - Amplitude signed or unsigned by format
// - Hold amplitude time ticks, 5/1 ms
// - Ramp flag interpolates to next amplitude
// - Ramp endpoint may itself start ramp
// - Play slots in order, stop at zero
// - Slot top bit: pause of 10 ms units
// - Loop each slot by its loop count
// - Replay whole sequence by repeat count
// - Start by launch bit or trigger pin
// - Launch write 1 starts, 0 stops
// - Level trigger ignores launch bit starts
// - Realtime mode drives until stop request
// - Sequencer ends by itself unless infinite
// - Brake phase before standby when enabled
// - Launch 0 or stop trigger ends early
`default_nettype none
module hws_sequencer
   import hws_pkg::*;
#(
   parameter int unsigned TICK_SLOW = TICK_SLOW_CYC,
   parameter int unsigned TICK_FAST = TICK_FAST_CYC,
   parameter int unsigned PAUSE_LEN = PAUSE_CYC,
   parameter int unsigned BRAKE_LEN = BRAKE_CYC
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // Register port
   input  wire logic       reg_wr_en,
   input  wire logic       reg_rd_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output var  logic [7:0] reg_rdata,
   // Library write port
   input  wire logic       mem_wr_en,
   input  wire logic [9:0] mem_wr_addr,
   input  wire logic [7:0] mem_wr_data,
   // Pins and format
   input  wire logic       trigger_interrupt_pin,
   input  wire logic       data_format_signed,
   // Drive outputs
   output var  logic [7:0] drive_amp,
   output var  logic       standby,
   output var  logic       braking,
   output var  logic       prog_error
);
   import hws_pkg::*;

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (TICK_SLOW < 1 || TICK_FAST < 1 || PAUSE_LEN < 1 || BRAKE_LEN < 1 ||
       TICK_SLOW > 24'hffffff || TICK_FAST > 24'hffffff ||
       PAUSE_LEN > 24'hffffff || BRAKE_LEN > 24'hffffff) begin : g_bad
      $error("hws_sequencer: cycle counts must lie in 1 to 2**24-1");
   end

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      hws_state_type   state;
      logic            go;
      logic            trig_prev;
      logic            perr;
      logic [7:0][7:0] slot;
      logic [15:0]     loops;
      logic [2:0]      mainl;
      logic [1:0]      mode;
      logic [1:0]      tfunc;
      logic            brk_en;
      logic            intv;
      logic [7:0]      realtime_playback;
      logic [7:0]      rdata;
      logic [3:0]      idx;
      logic [2:0]      main_left;
      logic [1:0]      sloop_left;
      logic [2:0]      erep;
      logic [2:0]      erep_left;
      logic [9:0]      base;
      logic [4:0]      size;
      logic [4:0]      pos;
      logic [1:0]      bcnt;
      logic            ph;
      logic [7:0]      v1;
      logic [7:0]      v2;
      logic [7:0]      tim;
      logic [7:0]      k;
      logic [23:0]     cyc;
      logic [6:0]      wleft;
      logic [7:0]      amp;
      logic [9:0]      rd_addr;
   } hws_core_type;

   hws_core_type st_r;
   hws_core_type st_nxt;

   // ==========================================================
   // Library memory
   // ==========================================================
   hws_mem_if mif ();
   assign mif.wr_en   = mem_wr_en;
   assign mif.wr_addr = mem_wr_addr;
   assign mif.wr_data = mem_wr_data;
   assign mif.rd_addr = st_r.rd_addr;

   hws_wave_mem u_mem (
      .core_clk (core_clk),
      .mp       (mif.mem)
   );

   // ==========================================================
   // Helpers
   // ==========================================================
   // Widen a 7-bit amplitude per the data format
   function automatic logic signed [9:0] hws_widen(input logic [6:0] v,
                                                    input logic sgn);
      hws_widen = sgn ? 10'(signed'(v)) : {3'h0, v};
   endfunction : hws_widen

   // Point on the line from a to b after k of t ticks
   function automatic logic [7:0] hws_interp(input logic [6:0] a,
                                             input logic [6:0] b,
                                             input logic [7:0] k,
                                             input logic [7:0] t,
                                             input logic sgn);
      logic signed [9:0]  wa;
      logic signed [9:0]  wb;
      logic signed [19:0] prod;
      logic signed [19:0] quo;
      wa   = hws_widen(a, sgn);
      wb   = hws_widen(b, sgn);
      prod = 20'(wb - wa) * signed'({12'h000, k});
      quo  = prod / signed'({12'h000, t});
      hws_interp = 8'(wa + 10'(quo));
   endfunction : hws_interp

   logic        wr_hit_go;
   logic        trig_rise;
   logic        trig_fall;
   logic        start_req;
   logic        stop_req;
   logic [23:0] tick_len;
   logic [7:0]  slot_now;
   logic [9:0]  hdr_base;
   logic        pair_done;

   always_comb begin
      wr_hit_go = reg_wr_en && (reg_addr == REG_LAUNCH);
      trig_rise = trigger_interrupt_pin && !st_r.trig_prev;
      trig_fall = !trigger_interrupt_pin && st_r.trig_prev;
      start_req = (wr_hit_go && reg_wdata[0] && st_r.tfunc != TPIN_LEVEL) ||
                  (trig_rise && st_r.tfunc == TPIN_PULSE) ||
                  (trig_rise && st_r.tfunc == TPIN_LEVEL);
      stop_req  = (wr_hit_go && !reg_wdata[0]) ||
                  (trig_rise && st_r.tfunc == TPIN_PULSE) ||
                  (trig_fall && st_r.tfunc == TPIN_LEVEL);
      tick_len  = st_r.intv ? 24'(TICK_FAST - 1) : 24'(TICK_SLOW - 1);
      slot_now  = st_r.slot[st_r.idx[2:0]];
      // three bytes per ID, after revision
      hdr_base  = 10'(HDR_BYTES) * {3'h0, slot_now[6:0]} - 10'h002;
      pair_done = (st_r.cyc == tick_len) && (st_r.k + 8'h01 >= st_r.tim);
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_nxt = st_r;
      st_nxt.trig_prev = trigger_interrupt_pin;

      // Register writes
      if (reg_wr_en) begin
         case (reg_addr)
            REG_CTRL1: begin
               st_nxt.mode  = reg_wdata[MODE_LSB +: 2];
               st_nxt.tfunc = reg_wdata[TFUNC_LSB +: 2];
            end
            REG_CTRL2:   st_nxt.brk_en     = reg_wdata[BRAKE_BIT];
            REG_PLAY:    st_nxt.intv       = reg_wdata[INTV_BIT];
            REG_RTP:     st_nxt.realtime_playback        = reg_wdata;
            REG_LOOP_LO: st_nxt.loops[7:0] = reg_wdata;
            REG_LOOP_HI: st_nxt.loops[15:8] = reg_wdata;
            REG_MAIN:    st_nxt.mainl      = reg_wdata[2:0];
            default: begin
               if (reg_addr >= REG_SLOT1 && reg_addr < REG_SLOT1 + 8'h08) begin
                  st_nxt.slot[3'(reg_addr - REG_SLOT1)] = reg_wdata;
               end
            end
         endcase
      end

      // Register reads; error flag clears on a status read
      if (reg_rd_en) begin
         case (reg_addr)
            REG_STATUS: begin
               st_nxt.rdata = 8'(st_r.perr) << STAT_ERR_BIT;
               st_nxt.perr  = 1'b0;
            end
            REG_CTRL1:   st_nxt.rdata = {4'h0, st_r.tfunc, st_r.mode};
            REG_CTRL2:   st_nxt.rdata = 8'(st_r.brk_en) << BRAKE_BIT;
            REG_LAUNCH:  st_nxt.rdata = {7'h00, st_r.go};
            REG_PLAY:    st_nxt.rdata = 8'(st_r.intv) << INTV_BIT;
            REG_RTP:     st_nxt.rdata = st_r.realtime_playback;
            REG_LOOP_LO: st_nxt.rdata = st_r.loops[7:0];
            REG_LOOP_HI: st_nxt.rdata = st_r.loops[15:8];
            REG_MAIN:    st_nxt.rdata = {5'h00, st_r.mainl};
            default: begin
               if (reg_addr >= REG_SLOT1 && reg_addr < REG_SLOT1 + 8'h08) begin
                  st_nxt.rdata = st_r.slot[3'(reg_addr - REG_SLOT1)];
               end else begin
                  st_nxt.rdata = 8'h00;
               end
            end
         endcase
      end

      // Playback engine
      case (st_r.state)
         ST_IDLE: begin
            st_nxt.amp = 8'h00;
            if (start_req && st_r.mode == MODE_RTP) begin
               st_nxt.go    = 1'b1;
               st_nxt.state = ST_RTP;
            end else if (start_req && st_r.mode == MODE_SEQ) begin
               st_nxt.go        = 1'b1;
               st_nxt.idx       = 4'h0;
               st_nxt.main_left = st_r.mainl;
               st_nxt.state     = ST_SLOT;
            end
         end
         ST_RTP: begin
            st_nxt.amp = st_r.realtime_playback;
         end
         ST_SLOT: begin
            st_nxt.amp = 8'h00;
            // end after eighth slot or at zero
            if (st_r.idx[3] || slot_now == 8'h00) begin
               if (st_r.mainl == REP_FOREVER || st_r.main_left != 3'h0) begin
                  if (st_r.mainl != REP_FOREVER) begin
                     st_nxt.main_left = st_r.main_left - 3'h1;
                  end
                  st_nxt.idx = 4'h0;
               end else begin
                  st_nxt.go    = 1'b0;
                  st_nxt.state = st_r.brk_en ? ST_BRAKE : ST_IDLE;
                  st_nxt.cyc   = 24'h000000;
               end
            end else if (slot_now[7]) begin
               st_nxt.wleft = slot_now[6:0];
               st_nxt.cyc   = 24'h000000;
               st_nxt.state = ST_PAUSE;
            end else begin
               st_nxt.sloop_left = st_r.loops[{st_r.idx[2:0], 1'b0} +: 2];
               st_nxt.bcnt       = 2'h0;
               st_nxt.ph         = 1'b0;
               st_nxt.state      = ST_HDR;
            end
         end
         ST_HDR: begin
            if (!st_r.ph) begin
               st_nxt.rd_addr = hdr_base + {8'h00, st_r.bcnt};
               st_nxt.ph      = 1'b1;
            end else begin
               st_nxt.ph   = 1'b0;
               st_nxt.bcnt = st_r.bcnt + 2'h1;
               case (st_r.bcnt)
                  2'h0: st_nxt.base[9:8] = mif.rd_data[1:0];
                  2'h1: st_nxt.base[7:0] = mif.rd_data;
                  default: begin
                     st_nxt.size      = mif.rd_data[CFG_SIZE_LSB +: 5];
                     st_nxt.erep      = mif.rd_data[CFG_REP_LSB +: 3];
                     st_nxt.erep_left = mif.rd_data[CFG_REP_LSB +: 3];
                     st_nxt.pos       = 5'h00;
                     st_nxt.bcnt      = 2'h0;
                     if (mif.rd_data[CFG_SIZE_LSB +: 5] == 5'h00 ||
                         mif.rd_data[CFG_SIZE_LSB] ||
                         mif.rd_data[CFG_SIZE_LSB +: 5] > SIZE_MAX) begin
                        st_nxt.perr  = 1'b1;
                        st_nxt.go    = 1'b0;
                        st_nxt.state = st_r.brk_en ? ST_BRAKE : ST_IDLE;
                        st_nxt.cyc   = 24'h000000;
                     end else begin
                        st_nxt.state = ST_DATA;
                     end
                  end
               endcase
            end
         end
         ST_DATA: begin
            if (!st_r.ph) begin
               st_nxt.rd_addr = st_r.base + {5'h00, st_r.pos} + {8'h00, st_r.bcnt};
               st_nxt.ph      = 1'b1;
            end else begin
               st_nxt.ph   = 1'b0;
               st_nxt.bcnt = st_r.bcnt + 2'h1;
               case (st_r.bcnt)
                  2'h0: st_nxt.v1  = mif.rd_data;
                  2'h1: st_nxt.tim = mif.rd_data;
                  default: st_nxt.v2 = mif.rd_data;
               endcase
               if (st_r.bcnt == 2'h2 || (st_r.bcnt == 2'h1 && !st_r.v1[7])) begin
                  st_nxt.bcnt  = 2'h0;
                  st_nxt.pos   = st_r.pos + 5'h02;
                  st_nxt.k     = 8'h00;
                  st_nxt.cyc   = 24'h000000;
                  st_nxt.state = ST_HOLD;
               end
            end
         end
         ST_HOLD: begin
            if (st_r.v1[7] && st_r.tim != 8'h00) begin
               st_nxt.amp = hws_interp(st_r.v1[6:0], st_r.v2[6:0], st_r.k, st_r.tim,
                                       data_format_signed);
            end else begin
               st_nxt.amp = 8'(hws_widen(st_r.v1[6:0], data_format_signed));
            end
            st_nxt.cyc = st_r.cyc + 24'h000001;
            if (st_r.cyc == tick_len) begin
               st_nxt.cyc = 24'h000000;
               st_nxt.k   = st_r.k + 8'h01;
            end
            if (st_r.tim == 8'h00 || pair_done) begin
               if (st_r.pos < st_r.size) begin
                  st_nxt.state = ST_DATA;
               end else if (st_r.erep == REP_FOREVER) begin
                  st_nxt.pos   = 5'h00;
                  st_nxt.state = ST_DATA;
               end else if (st_r.erep_left != 3'h0) begin
                  st_nxt.erep_left = st_r.erep_left - 3'h1;
                  st_nxt.pos       = 5'h00;
                  st_nxt.state     = ST_DATA;
               end else if (st_r.sloop_left != 2'h0) begin
                  st_nxt.sloop_left = st_r.sloop_left - 2'h1;
                  st_nxt.erep_left  = st_r.erep;
                  st_nxt.pos        = 5'h00;
                  st_nxt.state      = ST_DATA;
               end else begin
                  st_nxt.idx   = st_r.idx + 4'h1;
                  st_nxt.state = ST_SLOT;
               end
            end
         end
         ST_PAUSE: begin
            st_nxt.amp = 8'h00;
            st_nxt.cyc = st_r.cyc + 24'h000001;
            if (st_r.wleft == 7'h00) begin
               st_nxt.idx   = st_r.idx + 4'h1;
               st_nxt.state = ST_SLOT;
            end else if (st_r.cyc == 24'(PAUSE_LEN - 1)) begin
               st_nxt.cyc   = 24'h000000;
               st_nxt.wleft = st_r.wleft - 7'h01;
            end
         end
         ST_BRAKE: begin
            st_nxt.amp = 8'h00;
            st_nxt.cyc = st_r.cyc + 24'h000001;
            if (st_r.cyc == 24'(BRAKE_LEN - 1)) begin
               st_nxt.state = ST_IDLE;
            end
         end
         default: st_nxt.state = ST_IDLE;
      endcase

      // early stop wins over the engine
      if (stop_req && !st_r.state[0] && !st_r.state[7]) begin
         st_nxt.go    = 1'b0;
         st_nxt.amp   = 8'h00;
         st_nxt.cyc   = 24'h000000;
         st_nxt.state = st_r.brk_en ? ST_BRAKE : ST_IDLE;
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_r         <= '0;
         st_r.state   <= ST_IDLE;
         st_r.slot[0] <= RST_SLOT1;
         st_r.mode    <= RST_CTRL1[MODE_LSB +: 2];
         st_r.tfunc   <= RST_CTRL1[TFUNC_LSB +: 2];
         st_r.brk_en  <= RST_CTRL2[BRAKE_BIT];
         st_r.realtime_playback     <= RST_RTP;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state bits
   assign reg_rdata  = st_r.rdata;
   assign drive_amp  = st_r.amp;
   assign standby    = st_r.state[0];
   assign braking    = st_r.state[7];
   assign prog_error = st_r.perr;
endmodule : hws_sequencer
`default_nettype wire

/* hws_asserts.sv */
`default_nettype none
// ==========================================================
// Port checker
// ==========================================================
module hws_asserts
   import hws_pkg::*;
#(
   parameter int unsigned BRAKE_LEN = BRAKE_CYC
) (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       resetn,
   // Register port
   input wire logic       reg_wr_en,
   input wire logic       reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Drive outputs
   input wire logic [7:0] drive_amp,
   input wire logic       standby,
   input wire logic       braking,
   input wire logic       prog_error
);
   int unsigned brk_cnt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Brake length counter, cleared whenever braking drops
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) brk_cnt <= 0;
      else brk_cnt <= braking ? brk_cnt + 1 : 0;
   end
   // Stop request while driving, then wind-down
   sequence stop_req_s;
      reg_wr_en && reg_addr == REG_LAUNCH && !reg_wdata[0] && !standby && !braking;
   endsequence
   sequence wind_down_s;
      ##[1:2] (braking || standby);
   endsequence
   idle_quiet_a: assert property (standby |-> drive_amp == 8'h00)
      else $error("drive seen in standby");
   brake_excl_a: assert property (braking |-> !standby && drive_amp == 8'h00)
      else $error("brake overlaps standby or drive");
   brake_end_a: assert property ($fell(braking) |-> standby)
      else $error("brake did not end in standby");
   brake_len_a: assert property ($fell(braking) |-> brk_cnt == BRAKE_LEN)
      else $error("brake phase length wrong");
   stop_launch_a: assert property (stop_req_s |-> wind_down_s)
      else $error("launch clear did not stop");
   err_sticky_a: assert property (prog_error && !(reg_rd_en && reg_addr == REG_STATUS)
      |=> prog_error)
      else $error("error flag dropped");
   err_stop_a: assert property ($rose(prog_error) |-> ##[0:2] (standby || braking))
      else $error("bad size kept playing");
   launch_idle_a: assert property (reg_rd_en && reg_addr == REG_LAUNCH && standby
      && !reg_wr_en && !$past(reg_wr_en) |=> reg_rdata == 8'h00)
      else $error("launch bit set in standby");
endmodule : hws_asserts
bind hws_sequencer hws_asserts #(.BRAKE_LEN(BRAKE_LEN)) u_chk (.core_clk(core_clk),
   .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .drive_amp(drive_amp),
   .standby(standby), .braking(braking), .prog_error(prog_error));
`default_nettype wire

/* hws_host_model.sv */
`default_nettype none
// ==========================================================
// Host side: register writes, library load, trigger pin
// ==========================================================
module hws_host_model (
   // Clock and read data
   input  wire logic       core_clk,
   input  wire logic [7:0] reg_rdata,
   // Register and library ports
   output var  logic       reg_wr_en,
   output var  logic       reg_rd_en,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       mem_wr_en,
   output var  logic [9:0] mem_wr_addr,
   output var  logic [7:0] mem_wr_data,
   output var  logic       trigger_interrupt_pin
);
   // Quiet bus at time zero
   initial {reg_wr_en, reg_rd_en, reg_addr, reg_wdata, mem_wr_en, mem_wr_addr,
      mem_wr_data, trigger_interrupt_pin} = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      {reg_addr, reg_wdata, reg_wr_en} <= {a, d, 1'b1};
      @(posedge core_clk);
      {reg_wdata, reg_wr_en} <= {~d, 1'b0};
   endtask : wr
   // Data taken one edge after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      {reg_addr, reg_rd_en} <= {a, 1'b1};
      @(posedge core_clk);
      reg_rd_en <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask : rd
   task automatic lib(input logic [9:0] a, input logic [7:0] d);
      @(posedge core_clk);
      {mem_wr_addr, mem_wr_data, mem_wr_en} <= {a, d, 1'b1};
      @(posedge core_clk);
      {mem_wr_data, mem_wr_en} <= {~d, 1'b0};
   endtask : lib
   task automatic pin(input logic v);
      @(posedge core_clk);
      trigger_interrupt_pin <= v;
   endtask : pin
endmodule : hws_host_model
`default_nettype wire

/* tb_haptic_waveform_sequencer.sv */
`default_nettype none
module tb_haptic_waveform_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   import hws_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] e;} hws_row_type;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, mem_wr_data, drive_amp, d;
   logic [9:0]  mem_wr_addr;
   logic        core_clk, resetn, fmt, reg_wr_en, reg_rd_en, mem_wr_en, trig;
   logic        standby, braking, prog_error, saw_brk = 1'b0;
   int          failures = 0, n_tests = 0, cycles = 0;
   hws_row_type rows [7] = '{'{REG_CTRL1, RST_CTRL1 & 8'h0f}, '{REG_CTRL2, RST_CTRL2 & 8'h08},
      '{REG_RTP, RST_RTP}, '{REG_SLOT1, RST_SLOT1}, '{8'h10, 8'h00},
      '{REG_LAUNCH, 8'h00}, '{8'h30, 8'h00}};
   logic [7:0]  lib_img [7] = '{8'h00, 8'h00, 8'h04, 8'h02, 8'h20, 8'h03, 8'h00};
   hws_sequencer #(.TICK_SLOW(4), .TICK_FAST(2), .PAUSE_LEN(5), .BRAKE_LEN(6)) dut (
      .core_clk(core_clk), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
      .trigger_interrupt_pin(trig), .data_format_signed(fmt), .drive_amp(drive_amp),
      .standby(standby), .braking(braking), .prog_error(prog_error));
   hws_host_model u_host (.core_clk(core_clk), .reg_rdata(reg_rdata),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .trigger_interrupt_pin(trig));
   // 125 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Brake watcher and hang limit
   always @(posedge core_clk) begin
      cycles++;
      if (braking === 1'b1) saw_brk <= 1'b1;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // Main sequence
   initial begin
      resetn = 1'b0;
      fmt = 1'b0;
      repeat (3) @(posedge core_clk);
      chk("standby", {7'h00, standby}, 8'h01);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         u_host.rd(rows[i].a, d);
         chk("reg", d, rows[i].e);
      end
      // Realtime, brake off: runs until launch cleared
      u_host.wr(REG_CTRL1, 8'h00);
      u_host.wr(REG_CTRL2, 8'h00);
      u_host.wr(REG_LAUNCH, 8'h01);
      repeat (40) @(posedge core_clk);
      chk("amp", drive_amp, RST_RTP);
      u_host.wr(REG_RTP, 8'h15);
      repeat (3) @(posedge core_clk);
      chk("amp", drive_amp, 8'h15);
      u_host.wr(REG_LAUNCH, 8'h00);
      repeat (3) @(posedge core_clk);
      chk("standby", {7'h00, standby}, 8'h01);
      // Level pin: launch ignored, pin starts and stops
      u_host.wr(REG_CTRL1, 8'h04);
      u_host.wr(REG_LAUNCH, 8'h01);
      repeat (3) @(posedge core_clk);
      chk("standby", {7'h00, standby}, 8'h01);
      u_host.pin(1'b1);
      repeat (4) @(posedge core_clk);
      chk("standby", {7'h00, standby}, 8'h00);
      u_host.pin(1'b0);
      repeat (12) @(posedge core_clk);
      chk("standby", {7'h00, standby}, 8'h01);
      // Sequencer, one effect, brake on
      foreach (lib_img[i]) u_host.lib(10'(i), lib_img[i]);
      u_host.wr(REG_CTRL1, 8'h01);
      u_host.wr(REG_CTRL2, 8'h08);
      u_host.wr(REG_LAUNCH, 8'h01);
      for (int i = 0; i < 100 && drive_amp === 8'h00; i++) @(posedge core_clk);
      chk("amp", drive_amp, 8'h20);
      for (int i = 0; i < 200 && standby !== 1'b1; i++) @(posedge core_clk);
      chk("brake", {7'h00, saw_brk}, 8'h01);
      u_host.rd(REG_LAUNCH, d);
      chk("launch", d, 8'h00);
      // Odd effect size
      u_host.lib(10'h003, 8'h03);
      u_host.wr(REG_LAUNCH, 8'h01);
      repeat (20) @(posedge core_clk);
      chk("error", {7'h00, prog_error}, 8'h01);
      // Signed format: all-ones amplitude means minus one
      u_host.lib(10'h003, 8'h02);
      u_host.lib(10'h004, 8'h7f);
      fmt <= 1'b1;
      u_host.wr(REG_LAUNCH, 8'h01);
      for (int i = 0; i < 100 && drive_amp === 8'h00; i++) @(posedge core_clk);
      chk("amp", drive_amp, 8'hff);
      summarize();
   end
endmodule : tb_haptic_waveform_sequencer
`default_nettype wire
